// *** sqf_sequencer.sv ***
// Scan cycle sequencer with data queue and value table behind APB
`timescale 1ns/1ps

// How it works
// - Each backplane trigger line is enabled alone and pulsed from a chosen source
// - Initiate builds the scan list from algorithm and sequence channels, then waits
// - Each accepted trigger while waiting starts exactly one complete pass
// - Initiate flags a settings conflict if non-timer trigger lacks immediate gate
// - Initiate flags an error if, with timer trigger, algorithm time exceeds the timer interval
// - Timer trigger with held gate only readies; gate command starts triggers
// - Input phase latches digital inputs and scans listed channels, sequence ones to table or queue
// - Scan status variables become 0 normal, 1 disconnected, 3 out of sync
// - Sixteen scan status variables; verify phase skipped when none referenced
// - Updates are accepted any time but applied only in the update window
// - Variables change only during input and update phases; scan status variables change in verify
// - Calculate phase runs enabled algorithms, results go to the output buffer
// - Output phase sends results; its start is delayed from the trigger
// - Lowest ten table entries are reserved; the other 502 take algorithm writes
// - Each scanned sequence channel lands in a fixed table entry set by channel number
// - Table fills with NaN after reset; overvoltage stores plus or minus infinity
// - Queue holds 65,024 values; each write appends one, but a same-cycle algorithm write is lost to a scan value
// - Occupancy is readable; read request counts up to about 4.3 billion stream
// - Stop-when-full mode discards values once full; algorithms keep running
// - Measuring bit 4 of operation status is high whenever the sequencer is not idle
// - Keep-latest mode overwrites oldest values; queue read only when halted
// - In stop-when-full mode the first value beyond capacity sets questionable bit 10 and posts an error
// - After the programmed trigger count the sequencer returns to idle
module sqf_sequencer
  import sqf_pkg::*;
#(
  parameter int NCH    = 32,
  parameter int QDEPTH = Q_DEPTH_DOC,
  parameter int QAW    = 16,
  parameter int NTTL   = 8
) (
  input  wire logic              core_clk,        // System clock
  input  wire logic              rst,             // Async reset
  input  wire logic              psel,            // APB select
  input  wire logic              penable,         // APB enable
  input  wire logic              pwrite,          // APB direction
  input  wire logic [APB_AW-1:0] paddr,           // APB address
  input  wire logic [31:0]       pwdata,          // APB write data
  output logic      [31:0]       prdata,          // APB read data
  output logic                   pready,          // APB ready
  output logic                   pslverr,         // APB error
  input  wire logic              trigPulse,       // Selected trigger event
  input  wire logic              timerTick,       // Trigger timer cycled
  input  wire logic [NCH-1:0]    algChanRef,      // Channels used by algs
  input  wire logic [NSSV-1:0]   ssvRef,          // Status vars referenced
  input  wire logic [NSSV-1:0]   remoteConnected, // Remote unit present
  input  wire logic [NSSV-1:0]   remoteInSync,    // Remote list in sync
  input  wire sqf_scan_type      scanIn,          // Channel reading
  input  wire sqf_algwr_type     algWr,           // Algorithm data write
  input  wire logic              calcDone,        // Algorithms finished
  input  wire logic              outDone,         // Outputs all sent
  output logic [$clog2(NCH)-1:0] scanChan,        // Channel to scan
  output logic                   scanReq,         // Scan request pulse
  output logic                   digLatch,        // Latch digital inputs
  output logic                   varUpdEn,        // Variable access open
  output logic                   applyUpdate,     // Apply pending changes
  output logic                   calcStart,       // Start algorithms
  output logic                   outStart,        // Start output phase
  output logic                   timerRun,        // Let trigger timer run
  output logic                   measuring,       // Sequencer not idle
  output logic [NTTL-1:0]        ttlOut,          // Backplane line level
  output logic [NTTL-1:0]        ttlOe            // Backplane line enable
);

  localparam int CHW = $clog2(NCH);
  localparam logic [QAW-1:0] QLAST = QAW'(QDEPTH - 1);
  localparam logic [QAW:0]   QFULL = (QAW + 1)'(QDEPTH);
  localparam logic [CHW:0]   CHEND = (CHW + 1)'(NCH);
  localparam logic [8:0]     TBL_LAST = 9'(TBL_DEPTH - 1);

  function automatic logic [QAW-1:0] qInc(input logic [QAW-1:0] p);
    return (p == QLAST) ? '0 : p + 1'b1;
  endfunction : qInc

  function automatic logic [31:0] setClr(input logic [31:0] old,
                                         input logic [31:0] set,
                                         input logic [31:0] clr);
    return (old & ~clr) | set;
  endfunction : setClr

  function automatic logic [1:0] ssvCode(input logic conn,
                                         input logic sync);
    if (!conn) return SSV_DISC;
    if (!sync) return SSV_UNSYNC;
    return SSV_NORMAL;
  endfunction : ssvCode

  sqf_state_type    state_r;
  sqf_state_type    state_nxt;
  logic [31:0]      cfg_r;
  logic [31:0]      trigCount_r;
  logic [31:0]      timerIvl_r;
  logic [31:0]      algTime_r;
  logic [31:0]      outDelay_r;
  logic [31:0]      updSlots_r;
  logic [NTTL-1:0]  ttlEn_r;
  logic [NCH-1:0]   seqMask_r;
  logic [NCH-1:0]   scanList_r;
  logic [31:0]      err_r;
  logic [31:0]      ssv_r;
  logic [31:0]      ssvNxt;
  logic [31:0]      reqLeft_r;
  logic [31:0]      trigLeft_r;
  logic [31:0]      delayCnt_r;
  logic [31:0]      updCnt_r;
  logic             quesOvf_r;
  logic             armed_r;
  logic             updPend_r;
  logic             scanBusy_r;
  logic             outSent_r;
  logic [CHW:0]     chanIdx_r;
  logic [31:0]      qMem [QDEPTH];
  logic [QAW-1:0]   qWr_r;
  logic [QAW-1:0]   qRd_r;
  logic [QAW:0]     qCnt_r;
  logic [31:0]      tblMem [TBL_DEPTH];
  logic [8:0]       fillIdx_r;
  logic             filling_r;
  logic [31:0]      prdata_r;
  logic             pready_r;
  logic             pslverr_r;
  logic [31:0]      rdVal;
  logic             badAddr;

  // Bus decode
  wire       access   = psel & penable & ~pready_r;
  wire       isTbl    = paddr[TBL_SEL_BIT];
  wire [8:0] tblIdx   = paddr[10:2];
  wire       isQData  = ~isTbl & ~pwrite & (paddr == REG_Q_DATA);
  wire       running  = (state_r != S_IDLE);
  wire       qEmpty   = (qCnt_r == '0);
  wire       qFull    = (qCnt_r == QFULL);
  wire       qOver    = cfg_r[CFG_Q_OVER];
  wire       qRdBlock = qOver & running;
  wire       qWait    = isQData & qEmpty & ~qRdBlock
                        & (reqLeft_r != '0) & running;
  wire       answer   = access & ~qWait;
  wire       wrEn     = psel & penable & pready_r & pwrite & ~isTbl;
  wire       rdEn     = answer & ~pwrite;
  wire       qDataErr = isQData & (qEmpty | qRdBlock);
  wire       ctrlWr   = wrEn & (paddr == REG_CTRL);
  wire       initCmd  = ctrlWr & pwdata[CTRL_INIT];
  wire       abortCmd = ctrlWr & pwdata[CTRL_ABORT];
  wire       gateCmd  = ctrlWr & pwdata[CTRL_GATE];
  wire       updCmd   = ctrlWr & pwdata[CTRL_UPDATE];
  wire       pop      = rdEn & isQData & ~qEmpty & ~qRdBlock;

  // Initiate checks
  wire trigTimer   = cfg_r[CFG_TRIG_TIMER];
  wire cfgConflict = ~trigTimer & ~cfg_r[CFG_GATE_IMM];
  wire tooSlow     = trigTimer & (algTime_r > timerIvl_r);
  wire initGo      = initCmd & ~running & ~cfgConflict & ~tooSlow;

  // Sequencing terms
  wire inWait     = (state_r == S_WAIT);
  wire inInput    = (state_r == S_INPUT);
  wire inOutput   = (state_r == S_OUTPUT);
  wire trigAccept = inWait & trigPulse & armed_r;
  wire tooFast    = trigPulse & running & ~inWait;
  wire chanAtEnd  = (chanIdx_r == CHEND);
  wire chanSet    = ~chanAtEnd & scanList_r[chanIdx_r[CHW-1:0]];
  wire scanHit    = inInput & scanBusy_r & scanIn.ack;
  wire scanIssue  = inInput & chanSet & ~scanBusy_r;
  wire chanStep   = inInput & ~chanAtEnd & (~chanSet | scanHit);
  wire outReady   = (delayCnt_r >= outDelay_r);
  wire outIssue   = inOutput & ~outSent_r & outReady;
  wire passEnd    = inOutput & outSent_r & outDone;
  wire lastPass   = (trigCount_r != '0) & (trigLeft_r == '0);
  wire enterUpd   = (state_nxt == S_UPDATE) & (state_r != S_UPDATE);
  wire enterCalc  = (state_nxt == S_CALC) & (state_r != S_CALC);
  wire applyNow   = enterUpd & updPend_r;
  wire armedNxt   = initGo ? ~(trigTimer & ~cfg_r[CFG_GATE_IMM])
                           : (armed_r | gateCmd);

  // Scan and algorithm data paths
  wire        scanFwd  = scanHit & seqMask_r[chanIdx_r[CHW-1:0]];
  wire [31:0] scanVal  = scanIn.ovPos ? FP_POS_INF :
                         scanIn.ovNeg ? FP_NEG_INF : scanIn.value;
  wire        algQ     = algWr.valid & algWr.toQueue;
  wire        qPushReq = (scanFwd & cfg_r[CFG_SCAN_Q]) | algQ;
  wire [31:0] qPushVal = scanFwd ? scanVal : algWr.value;
  wire        qDrop    = qPushReq & qFull & ~qOver;
  wire        qPush    = qPushReq & (~qFull | qOver);
  wire        qOvrw    = qPush & qFull;
  wire        qGrow    = qPush & ~qOvrw;
  wire        algTbl   = algWr.valid & algWr.toTbl
                         & (algWr.idx >= 9'(TBL_RESERVED));
  wire        scanTbl  = scanFwd & cfg_r[CFG_SCAN_TBL];
  wire        tblWe    = filling_r | scanTbl | algTbl;
  wire [8:0]  scanIdx  = 9'(TBL_RESERVED) + 9'(chanIdx_r);
  wire [8:0]  tblWa    = filling_r ? fillIdx_r :
                         scanTbl ? scanIdx : algWr.idx;
  wire [31:0] tblWd    = filling_r ? FP_NAN :
                         scanTbl ? scanVal : algWr.value;

  // Backplane trigger drive source
  wire [1:0] ttlSrc   = cfg_r[CFG_TTL_SRC +: 2];
  wire       ttlPulse = (ttlSrc == TTL_SRC_TIMER) ? timerTick :
                        (ttlSrc == TTL_SRC_TRIG)  ? trigAccept :
                        (ttlSrc == TTL_SRC_OUT)   ? outIssue : 1'b0;

  // Clear masks and error events
  wire [31:0] errClr = (wrEn && paddr == REG_ERROR) ? pwdata : '0;
  wire        ovfClr = wrEn && (paddr == REG_QUES) && pwdata[QUES_OVERFLOW];
  wire [31:0] errSet = {28'h0, qDrop & ~quesOvf_r,
                        tooFast,
                        initCmd & ~running & tooSlow,
                        initCmd & ~running & cfgConflict};

  always_comb begin
    state_nxt = state_r;
    if (abortCmd) begin
      state_nxt = S_IDLE;
    end else begin
      case (state_r)
        S_IDLE:   if (initGo) state_nxt = S_WAIT;
        S_WAIT:   if (trigAccept) state_nxt = S_INPUT;
        S_INPUT:  if (chanAtEnd) begin
          state_nxt = (ssvRef != '0) ? S_VERIFY : S_UPDATE;
        end
        S_VERIFY: state_nxt = S_UPDATE;
        S_UPDATE: if (updCnt_r == '0) state_nxt = S_CALC;
        S_CALC:   if (calcDone) state_nxt = S_OUTPUT;
        S_OUTPUT: if (passEnd) begin
          state_nxt = lastPass ? S_IDLE : S_WAIT;
        end
        default:  state_nxt = S_IDLE;
      endcase
    end
  end

  always_comb begin
    ssvNxt = ssv_r;
    for (int i = 0; i < NSSV; i++) begin
      if (ssvRef[i]) begin
        ssvNxt[2*i +: 2] = ssvCode(remoteConnected[i], remoteInSync[i]);
      end
    end
  end

  always_comb begin
    rdVal   = '0;
    badAddr = 1'b0;
    if (isTbl) begin
      rdVal = tblMem[tblIdx];
    end else begin
      case (paddr)
        REG_CTRL:       rdVal = '0;
        REG_CONFIG:     rdVal = cfg_r;
        REG_TRIG_COUNT: rdVal = trigCount_r;
        REG_TIMER_IVL:  rdVal = timerIvl_r;
        REG_ALG_TIME:   rdVal = algTime_r;
        REG_OUT_DELAY:  rdVal = outDelay_r;
        REG_UPD_SLOTS:  rdVal = updSlots_r;
        REG_TTL_EN:     rdVal = 32'(ttlEn_r);
        REG_SEQ_MASK:   rdVal = 32'(seqMask_r);
        REG_OPER:       rdVal = 32'(measuring) << OPER_MEASURING;
        REG_QUES:       rdVal = 32'(quesOvf_r) << QUES_OVERFLOW;
        REG_ERROR:      rdVal = err_r;
        REG_Q_COUNT:    rdVal = 32'(qCnt_r);
        REG_Q_REQ:      rdVal = reqLeft_r;
        REG_Q_DATA:     rdVal = qEmpty ? '0 : qMem[qRd_r];
        REG_SSV:        rdVal = ssv_r;
        default:        badAddr = 1'b1;
      endcase
    end
  end

  // APB answer, one wait state, more while a queue data read waits for requested data
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= answer;
      pslverr_r <= answer & (badAddr | (~pwrite & qDataErr)
                             | (pwrite & isTbl));
      if (rdEn) prdata_r <= (badAddr | qDataErr) ? '0 : rdVal;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_r       <= CFG_RESET;
      trigCount_r <= TRIG_COUNT_RESET;
      timerIvl_r  <= TIMER_IVL_RESET;
      algTime_r   <= '0;
      outDelay_r  <= '0;
      updSlots_r  <= UPD_SLOTS_RESET;
      ttlEn_r     <= '0;
      seqMask_r   <= '0;
    end else if (wrEn) begin
      case (paddr)
        REG_CONFIG:     cfg_r       <= pwdata;
        REG_TRIG_COUNT: trigCount_r <= pwdata;
        REG_TIMER_IVL:  timerIvl_r  <= pwdata;
        REG_ALG_TIME:   algTime_r   <= pwdata;
        REG_OUT_DELAY:  outDelay_r  <= pwdata;
        REG_UPD_SLOTS:  updSlots_r  <= pwdata;
        REG_TTL_EN:     ttlEn_r     <= pwdata[NTTL-1:0];
        REG_SEQ_MASK:   seqMask_r   <= pwdata[NCH-1:0];
        default:        ;
      endcase
    end
  end

  // Sticky flags, set wins over clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      err_r     <= '0;
      quesOvf_r <= 1'b0;
      updPend_r <= 1'b0;
    end else begin
      err_r     <= setClr(err_r, errSet, errClr);
      quesOvf_r <= qDrop | (quesOvf_r & ~ovfClr);
      updPend_r <= updCmd | (updPend_r & ~applyNow);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r    <= S_IDLE;
      armed_r    <= 1'b0;
      scanList_r <= '0;
      trigLeft_r <= '0;
    end else begin
      state_r <= state_nxt;
      armed_r <= (state_nxt != S_IDLE) & armedNxt;
      if (initGo) begin
        scanList_r <= seqMask_r | algChanRef;
        trigLeft_r <= trigCount_r;
      end else if (trigAccept && trigLeft_r != '0) begin
        trigLeft_r <= trigLeft_r - 1'b1;
      end
    end
  end

  // Per-pass counters and flags
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chanIdx_r  <= '0;
      scanBusy_r <= 1'b0;
      delayCnt_r <= '0;
      updCnt_r   <= '0;
      outSent_r  <= 1'b0;
      ssv_r      <= '0;
    end else begin
      if (trigAccept) chanIdx_r <= '0;
      else if (chanStep) chanIdx_r <= chanIdx_r + 1'b1;
      scanBusy_r <= inInput & (scanIssue | (scanBusy_r & ~scanHit));
      if (trigAccept) delayCnt_r <= '0;
      else if (delayCnt_r != '1) delayCnt_r <= delayCnt_r + 1'b1;
      if (enterUpd) updCnt_r <= 32'(updSlots_r * UPD_SLOT_CYC);
      else if (updCnt_r != '0) updCnt_r <= updCnt_r - 1'b1;
      outSent_r <= inOutput & (outSent_r | outIssue);
      if (state_r == S_VERIFY) ssv_r <= ssvNxt;
    end
  end

  // Registered control outputs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scanReq     <= 1'b0;
      scanChan    <= '0;
      digLatch    <= 1'b0;
      varUpdEn    <= 1'b0;
      applyUpdate <= 1'b0;
      calcStart   <= 1'b0;
      outStart    <= 1'b0;
      timerRun    <= 1'b0;
      measuring   <= 1'b0;
      ttlOut      <= '0;
      ttlOe       <= '0;
    end else begin
      scanReq     <= scanIssue;
      if (scanIssue) scanChan <= chanIdx_r[CHW-1:0];
      digLatch    <= trigAccept;
      varUpdEn    <= (state_nxt == S_INPUT)
                     | (state_nxt == S_UPDATE);
      applyUpdate <= applyNow;
      calcStart   <= enterCalc;
      outStart    <= outIssue;
      timerRun    <= trigTimer & (state_nxt != S_IDLE) & armedNxt;
      measuring   <= (state_nxt != S_IDLE);
      ttlOut      <= ttlEn_r & {NTTL{ttlPulse}};
      ttlOe       <= ttlEn_r;
    end
  end

  // Data queue pointers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      qWr_r     <= '0;
      qRd_r     <= '0;
      qCnt_r    <= '0;
      reqLeft_r <= '0;
    end else begin
      if (qPush) qWr_r <= qInc(qWr_r);
      if (pop | qOvrw) qRd_r <= qInc(qRd_r);
      if (qGrow & ~pop) qCnt_r <= qCnt_r + 1'b1;
      else if (pop & ~qGrow) qCnt_r <= qCnt_r - 1'b1;
      if (wrEn && paddr == REG_Q_REQ) reqLeft_r <= pwdata;
      else if (pop && reqLeft_r != '0) reqLeft_r <= reqLeft_r - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (qPush) qMem[qWr_r] <= qPushVal;
    if (tblWe) tblMem[tblWa] <= tblWd;
  end

  // Table fill after reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      filling_r <= 1'b1;
      fillIdx_r <= '0;
    end else if (filling_r) begin
      fillIdx_r <= fillIdx_r + 1'b1;
      if (fillIdx_r == TBL_LAST) filling_r <= 1'b0;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

endmodule : sqf_sequencer

// *** sqf_pkg.sv ***
// Shared constants, types and register map of the scan cycle sequencer
package sqf_pkg;

  localparam int APB_AW = 12;

  // Register byte offsets
  localparam logic [APB_AW-1:0] REG_CTRL       = 12'h000;
  localparam logic [APB_AW-1:0] REG_CONFIG     = 12'h004;
  localparam logic [APB_AW-1:0] REG_TRIG_COUNT = 12'h008;
  localparam logic [APB_AW-1:0] REG_TIMER_IVL  = 12'h00c;
  localparam logic [APB_AW-1:0] REG_ALG_TIME   = 12'h010;
  localparam logic [APB_AW-1:0] REG_OUT_DELAY  = 12'h014;
  localparam logic [APB_AW-1:0] REG_UPD_SLOTS  = 12'h018;
  localparam logic [APB_AW-1:0] REG_TTL_EN     = 12'h01c;
  localparam logic [APB_AW-1:0] REG_SEQ_MASK   = 12'h020;
  localparam logic [APB_AW-1:0] REG_OPER       = 12'h024;
  localparam logic [APB_AW-1:0] REG_QUES       = 12'h028;
  localparam logic [APB_AW-1:0] REG_ERROR      = 12'h02c;
  localparam logic [APB_AW-1:0] REG_Q_COUNT    = 12'h030;
  localparam logic [APB_AW-1:0] REG_Q_REQ      = 12'h034;
  localparam logic [APB_AW-1:0] REG_Q_DATA     = 12'h038;
  localparam logic [APB_AW-1:0] REG_SSV        = 12'h03c;
  localparam int                TBL_SEL_BIT    = 11;

  // Field positions
  localparam int CTRL_INIT      = 0;
  localparam int CTRL_ABORT     = 1;
  localparam int CTRL_GATE      = 2;
  localparam int CTRL_UPDATE    = 3;
  localparam int CFG_TRIG_TIMER = 0;
  localparam int CFG_GATE_IMM   = 1;
  localparam int CFG_Q_OVER     = 2;
  localparam int CFG_SCAN_Q     = 3;
  localparam int CFG_SCAN_TBL   = 4;
  localparam int CFG_TTL_SRC    = 8;
  localparam int OPER_MEASURING = 4;
  localparam int QUES_OVERFLOW  = 10;
  localparam int ERR_CONFLICT   = 0;
  localparam int ERR_TOO_SLOW   = 1;
  localparam int ERR_TOO_FAST   = 2;
  localparam int ERR_OVERFLOW   = 3;

  // Reset values
  localparam logic [31:0] CFG_RESET        = 32'h0000_0013;
  localparam logic [31:0] TRIG_COUNT_RESET = 32'h0000_0001;
  localparam logic [31:0] TIMER_IVL_RESET  = 32'h0000_2710;
  localparam logic [31:0] UPD_SLOTS_RESET  = 32'h0000_0014;

  // Backplane drive sources
  localparam logic [1:0] TTL_SRC_TIMER = 2'h0;
  localparam logic [1:0] TTL_SRC_TRIG  = 2'h1;
  localparam logic [1:0] TTL_SRC_OUT   = 2'h2;

  // Scan status codes
  localparam logic [1:0] SSV_NORMAL = 2'h0;
  localparam logic [1:0] SSV_DISC   = 2'h1;
  localparam logic [1:0] SSV_UNSYNC = 2'h3;

  localparam int NSSV         = 16;
  localparam int TBL_DEPTH    = 512;
  localparam int TBL_RESERVED = 10;
  localparam int Q_DEPTH_DOC  = 65024;

  localparam logic [31:0] FP_NAN     = 32'h7fc0_0000;
  localparam logic [31:0] FP_POS_INF = 32'h7f80_0000;
  localparam logic [31:0] FP_NEG_INF = 32'hff80_0000;

  // Timing
  localparam int CLK_MHZ     = 25;
  localparam int UPD_SLOT_NS = 1400;
  localparam int UPD_SLOT_CYC = (UPD_SLOT_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [6:0] {
    S_IDLE   = 7'h01,
    S_WAIT   = 7'h02,
    S_INPUT  = 7'h04,
    S_VERIFY = 7'h08,
    S_UPDATE = 7'h10,
    S_CALC   = 7'h20,
    S_OUTPUT = 7'h40
  } sqf_state_type;

  typedef struct packed {
    logic        ack;
    logic        ovPos;
    logic        ovNeg;
    logic [31:0] value;
  } sqf_scan_type;

  typedef struct packed {
    logic        valid;
    logic        toQueue;
    logic        toTbl;
    logic [8:0]  idx;
    logic [31:0] value;
  } sqf_algwr_type;

endpackage : sqf_pkg

// *** sqf_chk.sv ***
// Port assertions for the scan cycle sequencer
`timescale 1ns/1ps
module sqf_chk
  import sqf_pkg::*;
#(
  parameter int NCH  = 32,
  parameter int NTTL = 8
) (
  input wire logic            core_clk,    // Clock
  input wire logic            rst,         // Reset
  input wire logic            psel,        // APB select
  input wire logic            penable,     // APB enable
  input wire logic            pready,      // APB ready
  input wire logic            pslverr,     // APB error
  input wire logic            digLatch,    // Input latch
  input wire logic            varUpdEn,    // Variable access
  input wire logic            applyUpdate, // Apply changes
  input wire logic            calcStart,   // Calc start
  input wire logic            outStart,    // Output start
  input wire logic            timerRun,    // Timer may run
  input wire logic            measuring,   // Running
  input wire logic [NTTL-1:0] ttlOut,      // Line level
  input wire logic [NTTL-1:0] ttlOe        // Line enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_out_follows;
    ##[1:300] outStart;
  endsequence
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_wait: assert property (psel && penable && !pready
    |-> ##[1:300] pready)
    else $error("no APB answer");
  a_err_pair: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_ttl_enabled: assert property ((ttlOut & ~ttlOe) == '0)
    else $error("pulse on disabled line");
  a_latch_input: assert property (digLatch |->
    measuring && varUpdEn)
    else $error("latch outside input phase");
  a_apply_window: assert property (applyUpdate |-> varUpdEn)
    else $error("update applied outside window");
  a_calc_closed: assert property (calcStart |-> !varUpdEn [*4])
    else $error("variables open after calc");
  a_gate_run: assert property (timerRun |-> measuring)
    else $error("timer runs while idle");
  a_calc_output: assert property (calcStart |-> s_out_follows)
    else $error("no output phase after calc");
endmodule : sqf_chk

// *** sqf_meas_model.sv ***
// Measurement side model answering scans, calculation and output
`timescale 1ns/1ps
module sqf_meas_model
  import sqf_pkg::*;
(
  input  wire logic       core_clk,  // Clock
  input  wire logic       rst,       // Reset
  input  wire logic       scanReq,   // Scan request
  input  wire logic [4:0] scanChan,  // Channel
  input  wire logic       calcStart, // Calc start
  input  wire logic       outStart,  // Output start
  output sqf_scan_type    scanIn,    // Reading
  output logic            calcDone,  // Calc finished
  output logic            outDone    // Outputs sent
);
  logic [1:0] cnt_r, cd_r, od_r;
  logic [4:0] ch_r;
  wire        fin = cnt_r == 2'h1;
  assign calcDone = cd_r[1];
  assign outDone = od_r[1];
  // Odd channels answer fast, even ones slowly; idle data toggles
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      cd_r <= '0;
      od_r <= '0;
      ch_r <= '0;
      scanIn <= '0;
    end else begin
      cd_r <= {cd_r[0], calcStart};
      od_r <= {od_r[0], outStart};
      if (scanReq) ch_r <= scanChan;
      if (scanReq) cnt_r <= scanChan[0] ? 2'h1 : 2'h3;
      else if (cnt_r != 2'h0) cnt_r <= cnt_r - 2'h1;
      scanIn.ack <= fin;
      scanIn.ovPos <= fin && ch_r == 5'h2;
      scanIn.value <= fin ? {27'h200_0000, ch_r} : ~scanIn.value;
    end
  end
endmodule : sqf_meas_model

// *** sqf_sequencer_tb.sv ***
// Self-checking bench for the scan cycle sequencer
`timescale 1ns/1ps
module sqf_sequencer_tb;
  import sqf_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] d; logic e;} sqf_row_type;
  logic core_clk, rst, psel, penable, pwrite, trigPulse, pready, pslverr, er;
  logic scanReq, digLatch, varUpdEn, applyUpdate, calcStart, outStart;
  logic timerRun, measuring, calcDone, outDone;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] ssvRef, remoteConnected, remoteInSync;
  logic [4:0] scanChan;
  logic [7:0] ttlOut, ttlOe;
  sqf_scan_type scanIn;
  sqf_algwr_type algWr = '0;
  int failures = 0, checks = 0, ttlCnt = 0, i;
  sqf_row_type rows [8] = '{'{REG_CONFIG, CFG_RESET, 1'b0},
    '{REG_TRIG_COUNT, TRIG_COUNT_RESET, 1'b0},
    '{REG_TIMER_IVL, TIMER_IVL_RESET, 1'b0}, '{12'h040, 32'h0, 1'b1},
    '{REG_UPD_SLOTS, UPD_SLOTS_RESET, 1'b0},
    '{REG_OPER, 32'h0, 1'b0}, '{REG_Q_COUNT, 32'h0, 1'b0},
    '{12'h800, FP_NAN, 1'b0}};
  sqf_sequencer u_sqf_sequencer (.core_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .trigPulse, .timerTick(1'b0),
    .algChanRef('0), .ssvRef, .remoteConnected, .remoteInSync, .scanIn,
    .algWr, .calcDone, .outDone, .scanChan, .scanReq, .digLatch, .varUpdEn,
    .applyUpdate, .calcStart, .outStart, .timerRun, .measuring, .ttlOut, .ttlOe);
  sqf_meas_model u_sqf_meas_model (.core_clk, .rst, .scanReq, .scanChan,
    .calcStart, .outStart, .scanIn, .calcDone, .outDone);
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk) penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic trig;
    trigPulse <= 1'b1;
    @(posedge core_clk) trigPulse <= 1'b0;
  endtask : trig
  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #2000000;
    failures++;
    results;
  end
  always @(posedge core_clk) if (ttlOut[0] === 1'b1) ttlCnt <= ttlCnt + 1;
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, trigPulse} = {3'b100, 46'h0};
    {ssvRef, remoteConnected, remoteInSync} = {16'h3, 16'hfffe, 16'hfffd};
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (520) @(posedge core_clk);
    foreach (rows[k]) begin
      apb(0, rows[k].a, 0);
      chk({31'h0, er}, {31'h0, rows[k].e});
      if (!rows[k].e) chk(rd, rows[k].d);
    end
    apb(1, REG_CONFIG, 32'h10);
    apb(1, REG_CTRL, 32'h1);
    apb(0, REG_ERROR, 0);
    chk(rd, 32'h1);
    apb(1, REG_ERROR, 32'hf);
    apb(1, REG_CONFIG, 32'h11b);
    apb(1, REG_ALG_TIME, 32'h2711);
    apb(1, REG_CTRL, 32'h1);
    apb(0, REG_ERROR, 0);
    chk(rd, 32'h2);
    apb(1, REG_ERROR, 32'hf);
    apb(1, REG_ALG_TIME, 0);
    apb(1, REG_UPD_SLOTS, 1);
    apb(1, REG_SEQ_MASK, 32'h6);
    apb(1, REG_TRIG_COUNT, 2);
    apb(1, REG_TTL_EN, 1);
    apb(1, REG_CTRL, 32'h1);
    apb(1, REG_CTRL, 32'h8);
    apb(0, REG_OPER, 0);
    chk(rd, 32'h10);
    trig();
    repeat (3) @(posedge core_clk);
    trig();
    for (i = 0; i < 300 && outStart !== 1'b1; i++) @(posedge core_clk);
    repeat (5) @(posedge core_clk);
    trig();
    for (i = 0; i < 300 && measuring !== 1'b0; i++) @(posedge core_clk);
    apb(0, REG_ERROR, 0);
    chk(rd, 32'h4);
    apb(0, REG_OPER, 0);
    chk(rd, 32'h0);
    apb(0, REG_Q_COUNT, 0);
    chk(rd, 32'h4);
    apb(0, 12'h82c, 0);
    chk(rd, 32'h4000_0001);
    apb(0, 12'h830, 0);
    chk(rd, FP_POS_INF);
    apb(0, REG_SSV, 0);
    chk(rd, 32'hd);
    apb(0, REG_Q_DATA, 0);
    chk(rd, 32'h4000_0001);
    chk(ttlCnt, 32'h2);
    algWr <= {3'b101, 9'h5, 32'h1};
    apb(0, 12'h814, 0);
    chk(rd, FP_NAN);
    algWr <= {3'b101, 9'h14, 32'h1};
    apb(0, 12'h850, 0);
    chk(rd, 32'h1);
    results;
  end
endmodule : sqf_sequencer_tb
bind sqf_sequencer sqf_chk #(.NCH(NCH), .NTTL(NTTL)) u_sqf_chk (.core_clk,
  .rst, .psel, .penable, .pready, .pslverr, .digLatch, .varUpdEn,
  .applyUpdate, .calcStart, .outStart, .timerRun, .measuring, .ttlOut, .ttlOe);
